// ### common/pss_pkg.sv
package pss_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_SUMMARY   = 8'h40;  // printed offset 0x10, index times four
  localparam logic [7:0] ADDR_SRC_READ  = 8'h44;
  localparam logic [7:0] ADDR_IRQ_STAT  = 8'h48;
  localparam logic [7:0] ADDR_IRQ_CLR   = 8'h4C;
  localparam logic [7:0] ADDR_IRQ_EN    = 8'h50;
  localparam logic [7:0] ADDR_CTRL      = 8'h54;
  localparam int SUMMARY_INDEX = 16;
  // summary bit positions
  localparam int B_RSVD     = 15;
  localparam int B_XOVER    = 14;
  localparam int B_RXERR    = 13;
  localparam int B_POL      = 12;
  localparam int B_FCAR     = 11;
  localparam int B_SIGDET   = 10;
  localparam int B_DLOCK    = 9;
  localparam int B_PAGE     = 8;
  localparam int B_IRQ      = 7;
  localparam int B_RFAULT   = 6;
  localparam int B_JABBER   = 5;
  localparam int B_ANDONE   = 4;
  localparam int B_LOOP     = 3;
  localparam int B_DUPLEX   = 2;
  localparam int B_SPEED    = 1;
  localparam int B_LINK     = 0;
  // source-read strobe bits (write 1 to emulate a read of that register)
  localparam int S_RXCNT    = 0;
  localparam int S_FCCNT    = 1;
  localparam int S_TENB     = 2;
  localparam int S_ANEXP    = 3;
  localparam int S_ISR      = 4;
  localparam int S_BASIC_MODE_STATUS     = 5;
  // control bits
  localparam int C_XEN      = 0;
  localparam int C_XFORCE   = 1;
  localparam int C_ANEN     = 2;
  localparam int C_FDUP     = 3;
  localparam int C_F10      = 4;
  localparam logic [4:0] CTRL_RESET = 5'h05;
  // event/interrupt bits
  localparam int NEV        = 4;
  localparam int E_RXERR    = 0;
  localparam int E_FCAR     = 1;
  localparam int E_PAGE     = 2;
  localparam int E_RFAULT   = 3;
  localparam logic [15:0] SUMMARY_RESET = 16'h0000;
  localparam logic [1:0] SYNC_RESET = 2'h0;

  typedef struct packed {
    logic xover_live;
    logic rx_error;
    logic polarity_inv;
    logic false_carrier;
    logic signal_detect;
    logic descr_lock;
    logic page_rx;
    logic int_event;
    logic remote_fault;
    logic jabber;
    logic an_complete;
    logic loopback;
    logic an_duplex;
    logic an_speed10;
    logic link;
  } pss_stat_s;
endpackage : pss_pkg

// ### rtl/pss_sync.sv
`timescale 1ns/100ps
module pss_sync
(
  input  wire logic i_clk,
  input  wire logic i_rst_b,
  input  wire logic i_d,
  output logic      o_q
);
  logic [1:0] stage;
  logic [1:0] next_stage;

  always_comb
  begin
    next_stage = {stage[0], i_d};
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
      stage <= pss_pkg::SYNC_RESET;
    else
      stage <= next_stage;
  end

  assign o_q = stage[1];
endmodule : pss_sync

// ### rtl/pss_latch_bit.sv
`timescale 1ns/100ps
module pss_latch_bit
(
  input  wire logic i_clk,
  input  wire logic i_rst_b,
  input  wire logic i_set,
  input  wire logic i_clr,
  output logic      o_q
);
  logic q;
  logic next_q;

  // set wins over a clear in the same cycle so no event is lost
  always_comb
  begin
    next_q = q;
    if (i_clr)
      next_q = 1'b0;
    if (i_set)
      next_q = 1'b1;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
      q <= 1'b0;
    else
      q <= next_q;
  end

  assign o_q = q;
endmodule : pss_latch_bit

// ### rtl/pss_top.sv
`timescale 1ns/100ps
// Functional notes
// - bit 15 reads zero, writes ignored
// - bit 14: 1 pairs swapped, 0 normal
// - crossover bit follows enable/force; live update when auto and unforced
// - bit 13 latches receive error until receive error counter read
// - bit 12 latches polarity flag, cleared by tenbase status read only
// - bit 11 latches false carrier until false carrier counter read
// - bit 10 signal detect latched low until summary read
// - bit 9 descrambler lock latched low until summary read
// - bit 8 page received, cleared by expansion register read only
// - bit 7 interrupt pending, cleared by interrupt status read
// - jabber mirrors basic status, not cleared by summary read
// - autoneg complete flag 1 when finished
// - loopback flag 1 while loopback enabled
// - bit 2 duplex, from autoneg or forced setting
// - bit 1 speed, 1 for 10 Mb/s, from autoneg or forced
// - bit 0 mirrors link, not cleared by summary read
module pss_top
(
  input  wire logic              i_clk,
  input  wire logic              i_rst_b,
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [7:0]        i_paddr,
  input  wire logic [31:0]       i_pwdata,
  output logic      [31:0]       o_prdata,
  output logic                   o_pready,
  output logic                   o_pslverr,
  input  wire pss_pkg::pss_stat_s i_stat,
  output logic                   o_irq
);
  pss_pkg::pss_stat_s st;
  logic [14:0] raw;
  logic [14:0] syn;

  // status pins come from other clock domains of the phy
  assign raw = i_stat;
  for (genvar g = 0; g < 15; g++)
  begin : g_sync
    pss_sync u_sync (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_d(raw[g]), .o_q(syn[g]));
  end
  assign st = syn;

  logic acc;
  logic wr;
  logic rd;
  assign acc = i_psel && i_penable;
  assign wr  = acc && i_pwrite;
  assign rd  = acc && !i_pwrite;

  logic [5:0] src_rd;
  assign src_rd = (wr && i_paddr == pss_pkg::ADDR_SRC_READ) ? i_pwdata[5:0] : 6'h00;
  logic sum_rd;
  assign sum_rd = rd && i_paddr == pss_pkg::ADDR_SUMMARY;

  // edge detect on event inputs
  logic rxe_d;
  logic fc_d;
  logic pg_d;
  logic rf_d;
  logic ie_d;
  logic next_rxe_d;
  logic next_fc_d;
  logic next_pg_d;
  logic next_rf_d;
  logic next_ie_d;
  always_comb
  begin
    next_rxe_d = st.rx_error;
    next_fc_d  = st.false_carrier;
    next_pg_d  = st.page_rx;
    next_rf_d  = st.remote_fault;
    next_ie_d  = st.int_event;
  end
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      rxe_d <= 1'b0;
      fc_d  <= 1'b0;
      pg_d  <= 1'b0;
      rf_d  <= 1'b0;
      ie_d  <= 1'b0;
    end
    else
    begin
      rxe_d <= next_rxe_d;
      fc_d  <= next_fc_d;
      pg_d  <= next_pg_d;
      rf_d  <= next_rf_d;
      ie_d  <= next_ie_d;
    end
  end

  logic rxe_ev;
  logic fc_ev;
  logic pg_ev;
  logic rf_ev;
  logic ie_ev;
  assign rxe_ev = st.rx_error && !rxe_d;
  assign fc_ev  = st.false_carrier && !fc_d;
  assign pg_ev  = st.page_rx && !pg_d;
  assign rf_ev  = st.remote_fault && !rf_d;
  assign ie_ev  = st.int_event && !ie_d;

  logic rxerr_q;
  logic fcar_q;
  logic page_q;
  logic irq_q;
  logic rfault_q;
  pss_latch_bit u_rxerr (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_set(rxe_ev),
    .i_clr(src_rd[pss_pkg::S_RXCNT]), .o_q(rxerr_q));
  pss_latch_bit u_fcar (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_set(fc_ev),
    .i_clr(src_rd[pss_pkg::S_FCCNT]), .o_q(fcar_q));
  pss_latch_bit u_page (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_set(pg_ev),
    .i_clr(src_rd[pss_pkg::S_ANEXP]), .o_q(page_q));
  pss_latch_bit u_irq (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_set(ie_ev),
    .i_clr(src_rd[pss_pkg::S_ISR]), .o_q(irq_q));
  pss_latch_bit u_rflt (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_set(rf_ev),
    .i_clr(src_rd[pss_pkg::S_BASIC_MODE_STATUS]), .o_q(rfault_q));

  // polarity held until tenbase status read
  logic pol_q;
  logic next_pol_q;
  always_comb
  begin
    next_pol_q = pol_q;
    if (src_rd[pss_pkg::S_TENB])
      next_pol_q = 1'b0;
    if (st.polarity_inv)
      next_pol_q = 1'b1;
  end

  // latched-low: a loss holds zero until the summary register is read
  logic sd_q;
  logic dl_q;
  logic next_sd_q;
  logic next_dl_q;
  always_comb
  begin
    next_sd_q = sum_rd ? 1'b1 : sd_q;
    next_dl_q = sum_rd ? 1'b1 : dl_q;
    if (!st.signal_detect)
      next_sd_q = 1'b0;
    if (!st.descr_lock)
      next_dl_q = 1'b0;
  end

  // control: crossover and forced mode settings, interrupt enable and status
  logic [4:0] ctrl;
  logic [4:0] next_ctrl;
  logic [3:0] irq_en;
  logic [3:0] next_irq_en;
  logic [3:0] irq_st;
  logic [3:0] next_irq_st;
  logic [3:0] ev_vec;
  assign ev_vec = {rf_ev, pg_ev, fc_ev, rxe_ev};
  always_comb
  begin
    next_ctrl   = ctrl;
    next_irq_en = irq_en;
    if (wr && i_paddr == pss_pkg::ADDR_CTRL)
      next_ctrl = i_pwdata[4:0];
    if (wr && i_paddr == pss_pkg::ADDR_IRQ_EN)
      next_irq_en = i_pwdata[3:0];
    next_irq_st = irq_st;
    if (wr && i_paddr == pss_pkg::ADDR_IRQ_CLR)
      next_irq_st = irq_st & ~i_pwdata[3:0];
    next_irq_st = next_irq_st | ev_vec;
  end

  logic xover;
  logic duplex;
  logic speed10;
  always_comb
  begin
    if (ctrl[pss_pkg::C_XFORCE])
      xover = 1'b1;
    else if (ctrl[pss_pkg::C_XEN])
      xover = st.xover_live;
    else
      xover = 1'b0;
    if (ctrl[pss_pkg::C_ANEN])
    begin
      duplex  = st.an_duplex;
      speed10 = st.an_speed10;
    end
    else
    begin
      duplex  = ctrl[pss_pkg::C_FDUP];
      speed10 = ctrl[pss_pkg::C_F10];
    end
  end

  logic [15:0] summary;
  always_comb
  begin
    summary = pss_pkg::SUMMARY_RESET;
    summary[pss_pkg::B_RSVD]   = 1'b0;
    summary[pss_pkg::B_XOVER]  = xover;
    summary[pss_pkg::B_RXERR]  = rxerr_q;
    summary[pss_pkg::B_POL]    = pol_q;
    summary[pss_pkg::B_FCAR]   = fcar_q;
    summary[pss_pkg::B_SIGDET] = sd_q;
    summary[pss_pkg::B_DLOCK]  = dl_q;
    summary[pss_pkg::B_PAGE]   = page_q;
    summary[pss_pkg::B_IRQ]    = irq_q;
    summary[pss_pkg::B_RFAULT] = rfault_q;
    summary[pss_pkg::B_JABBER] = st.jabber;
    summary[pss_pkg::B_ANDONE] = st.an_complete;
    summary[pss_pkg::B_LOOP]   = st.loopback;
    summary[pss_pkg::B_DUPLEX] = duplex;
    summary[pss_pkg::B_SPEED]  = speed10;
    summary[pss_pkg::B_LINK]   = st.link;
  end

  // apb: one wait-free access phase, read data registered
  logic [31:0] next_prdata;
  logic        next_pslverr;
  logic        next_irq;
  always_comb
  begin
    next_prdata  = 32'h0000_0000;
    next_pslverr = 1'b0;
    if (i_psel && !i_penable)
    begin
      if (i_paddr == pss_pkg::ADDR_SUMMARY)
        next_prdata = {16'h0000, summary};
      else if (i_paddr == pss_pkg::ADDR_IRQ_STAT)
        next_prdata = {28'h0000000, irq_st};
      else if (i_paddr == pss_pkg::ADDR_IRQ_EN)
        next_prdata = {28'h0000000, irq_en};
      else if (i_paddr == pss_pkg::ADDR_CTRL)
        next_prdata = {27'h0000000, ctrl};
      else if (i_paddr == pss_pkg::ADDR_SRC_READ || i_paddr == pss_pkg::ADDR_IRQ_CLR)
        next_prdata = 32'h0000_0000;
      else
        next_pslverr = 1'b1;
    end
    next_irq = |(next_irq_st & next_irq_en);
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      pol_q     <= 1'b0;
      sd_q      <= 1'b0;
      dl_q      <= 1'b0;
      ctrl      <= pss_pkg::CTRL_RESET;
      irq_en    <= 4'h0;
      irq_st    <= 4'h0;
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'b0;
      o_pready  <= 1'b0;
      o_irq     <= 1'b0;
    end
    else
    begin
      pol_q     <= next_pol_q;
      sd_q      <= next_sd_q;
      dl_q      <= next_dl_q;
      ctrl      <= next_ctrl;
      irq_en    <= next_irq_en;
      irq_st    <= next_irq_st;
      o_prdata  <= next_prdata;
      o_pslverr <= next_pslverr;
      o_pready  <= i_psel && !i_penable;
      o_irq     <= next_irq;
    end
  end

  // a summary read while both sources are present must free the latched-low bits
  sequence s_clean_sum_read;
    sum_rd && st.signal_detect && st.descr_lock;
  endsequence

  a_rsvd_zero: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (o_pready && !o_pslverr) |-> !o_prdata[15])
    else $error("reserved summary bit read nonzero");
  a_rxerr_hold: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (rxerr_q && !src_rd[pss_pkg::S_RXCNT]) |=> rxerr_q)
    else $error("receive error latch dropped without counter read");
  a_fcar_hold: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (fcar_q && !src_rd[pss_pkg::S_FCCNT]) |=> fcar_q)
    else $error("false carrier latch dropped without counter read");
  a_sigdet_low: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (!st.signal_detect) |=> !sd_q)
    else $error("signal detect loss not latched");
  a_lock_low: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (!dl_q && !sum_rd) |=> !dl_q)
    else $error("descrambler lock loss released without read");
  a_latch_release: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    s_clean_sum_read |=> (sd_q && dl_q))
    else $error("latched-low bits not released by summary read");
  a_page_hold: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (page_q && sum_rd && !src_rd[pss_pkg::S_ANEXP]) |=> page_q)
    else $error("page flag cleared by summary read");
  a_pol_hold: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (pol_q && !src_rd[pss_pkg::S_TENB]) |=> pol_q)
    else $error("polarity flag dropped without source read");
  a_rflt_hold: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (rfault_q && !src_rd[pss_pkg::S_BASIC_MODE_STATUS]) |=> rfault_q)
    else $error("remote fault dropped without status read");
  a_irq_level: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    ((|(ev_vec & irq_en)) && !(wr && i_paddr == pss_pkg::ADDR_IRQ_EN)) |=> o_irq)
    else $error("enabled event did not raise interrupt");
endmodule : pss_top

// ### testbench/pss_top_tb.sv
`timescale 1ns/100ps
module pss_top_tb;
  logic               i_clk = 1'b0;
  logic               i_rst_b = 1'b0;
  logic               i_psel = 1'b0;
  logic               i_penable = 1'b0;
  logic               i_pwrite = 1'b0;
  logic [7:0]         i_paddr = 8'h00;
  logic [31:0]        i_pwdata = 32'h0;
  logic [31:0]        o_prdata;
  logic               o_pready;
  logic               o_pslverr;
  pss_pkg::pss_stat_s i_stat = '0;
  logic               o_irq;
  int                 bad_count = 0;
  int                 n_compared = 0;
  logic [31:0]        rd;
  logic               err;
  logic [14:0]        base;

  always #5 i_clk = ~i_clk;

  pss_top pss_top_inst
  (
    .i_clk     (i_clk),
    .i_rst_b   (i_rst_b),
    .i_psel    (i_psel),
    .i_penable (i_penable),
    .i_pwrite  (i_pwrite),
    .i_paddr   (i_paddr),
    .i_pwdata  (i_pwdata),
    .o_prdata  (o_prdata),
    .o_pready  (o_pready),
    .o_pslverr (o_pslverr),
    .i_stat    (i_stat),
    .o_irq     (o_irq)
  );

  task end_sim;
    if (bad_count == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_sim

  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task wt(input int n);
    repeat (n) @(posedge i_clk);
  endtask : wt

  // one idle edge first, so a release is never overridden in the same step
  task apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
    @(posedge i_clk);
    i_psel    <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite  <= wr;
    i_paddr   <= addr;
    i_pwdata  <= wd;
    @(posedge i_clk);
    i_penable <= 1'b1;
    @(posedge i_clk);
    while (o_pready !== 1'b1)
      @(posedge i_clk);
    rd = o_prdata;
    err = o_pslverr;
    i_psel    <= 1'b0;
    i_penable <= 1'b0;
  endtask : apb

  task rd_sum;
    apb(1'b0, pss_pkg::ADDR_SUMMARY, 32'h0);
  endtask : rd_sum

  task t_reset;
    rd_sum();
    chk("summary", rd, 32'h0);
    apb(1'b0, pss_pkg::ADDR_CTRL, 32'h0);
    chk("ctrl", rd, 32'h5);
    apb(1'b1, pss_pkg::ADDR_SUMMARY, 32'hFFFF_FFFF);
    rd_sum();
    chk("summary", rd, 32'h0);
    apb(1'b0, 8'h00, 32'h0);
    chk("slverr", {31'h0, err}, 32'h1);
    chk("bad data", rd, 32'h0);
  endtask : t_reset

  task t_mirror;
    base = 15'h063D;
    i_stat <= base;
    wt(5);
    rd_sum();
    rd_sum();
    chk("summary", rd, 32'h063D);
    base = 15'h063F;
    i_stat <= base;
    wt(5);
    rd_sum();
    chk("summary", rd, 32'h063F);
    for (int b = 9; b <= 10; b++)
    begin
      i_stat <= base & ~(15'h1 << b);
      wt(3);
      i_stat <= base;
      wt(5);
      rd_sum();
      chk("low latch", {31'h0, rd[b]}, 32'h0);
      rd_sum();
      chk("low latch", {31'h0, rd[b]}, 32'h1);
    end
  endtask : t_mirror

  task t_events;
    int eb[6];
    int es[6];
    eb = '{13, 11, 12, 8, 6, 7};
    es = '{0, 1, 2, 3, 5, 4};
    for (int i = 0; i < 6; i++)
    begin
      i_stat <= base | (15'h1 << eb[i]);
      wt(3);
      i_stat <= base;
      wt(5);
      rd_sum();
      chk("event", {31'h0, rd[eb[i]]}, 32'h1);
      rd_sum();
      chk("event", {31'h0, rd[eb[i]]}, 32'h1);
      apb(1'b1, pss_pkg::ADDR_SRC_READ, 32'h1 << es[i]);
      wt(2);
      rd_sum();
      chk("cleared", {31'h0, rd[eb[i]]}, 32'h0);
      chk("others", rd & 32'h063F, 32'h063F);
    end
  endtask : t_events

  task t_irq;
    apb(1'b0, pss_pkg::ADDR_IRQ_STAT, 32'h0);
    chk("irq status", rd & 32'hF, 32'hF);
    chk("irq", {31'h0, o_irq}, 32'h0);
    apb(1'b1, pss_pkg::ADDR_IRQ_EN, 32'h2);
    wt(2);
    chk("irq", {31'h0, o_irq}, 32'h1);
    apb(1'b1, pss_pkg::ADDR_IRQ_CLR, 32'h2);
    wt(2);
    chk("irq", {31'h0, o_irq}, 32'h0);
    apb(1'b0, pss_pkg::ADDR_IRQ_STAT, 32'h0);
    chk("irq status", rd & 32'hF, 32'hD);
    // a fresh false carrier event with its enable still set must raise the line again
    i_stat <= base | 15'h0800;
    wt(3);
    i_stat <= base;
    wt(5);
    chk("irq event", {31'h0, o_irq}, 32'h1);
    apb(1'b1, pss_pkg::ADDR_IRQ_CLR, 32'hF);
    apb(1'b1, pss_pkg::ADDR_IRQ_EN, 32'h0);
  endtask : t_irq

  task t_xover;
    i_stat <= base | 15'h4000;
    wt(5);
    rd_sum();
    chk("xover auto", {31'h0, rd[14]}, 32'h1);
    i_stat <= base;
    wt(5);
    rd_sum();
    chk("xover auto", {31'h0, rd[14]}, 32'h0);
    apb(1'b1, pss_pkg::ADDR_CTRL, 32'h7);
    wt(2);
    rd_sum();
    chk("xover forced", {31'h0, rd[14]}, 32'h1);
    // autoneg and crossover off: forced duplex and speed, live swap ignored
    base = 15'h4639;
    i_stat <= base;
    apb(1'b1, pss_pkg::ADDR_CTRL, 32'h18);
    wt(5);
    rd_sum();
    chk("forced mode", {30'h0, rd[2:1]}, 32'h3);
    chk("xover off", {31'h0, rd[14]}, 32'h0);
  endtask : t_xover

  initial
  begin
    wt(5);
    i_rst_b <= 1'b1;
    t_reset();
    t_mirror();
    t_events();
    t_irq();
    t_xover();
    end_sim();
  end

  initial
  begin
    wt(20000);
    bad_count++;
    end_sim();
  end
endmodule : pss_top_tb
